// ### src/acx_pkg.sv
// Purpose: Shared constants, types and opcode decoding for the accumulator execution block
// Assumes: One oscillator clock per i_clk edge; APB data 32 bits wide
// Notes: Byte addresses of the APB register window and file register numbers live here

package acx_pkg;

  // ----------------------------------------------------------------
  // APB register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_INSTR = 12'h000;
  localparam logic [11:0] ADDR_ACC = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_CFG = 12'h00c;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [11:0] ADDR_TIMER = 12'h014;
  localparam logic [11:0] ADDR_PRESC = 12'h018;
  localparam logic [11:0] ADDR_IPTR = 12'h01c;
  localparam logic [2:0] FILE_WIN_TOP = 3'h1;

  // ----------------------------------------------------------------
  // File register numbers with special meaning
  // ----------------------------------------------------------------
  localparam logic [6:0] FILE_TIMER = 7'h01;
  localparam logic [6:0] FILE_IPTR = 7'h02;
  localparam logic [6:0] FILE_FLAGS = 7'h03;
  localparam logic [6:0] FILE_PORT = 7'h06;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int CFG_PSA = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NOP = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] LAST_PHASE = 2'(OSC_PER_INSTR - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP = 2'b11
  } acx_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD_IMM = 3'h1,
    OP_AND_IMM = 3'h2,
    OP_ADD_REG = 3'h3,
    OP_AND_REG = 3'h4
  } acx_op_t;

  typedef struct packed {
    acx_state_t state;
    logic [1:0] phase;
    logic [1:0] tick;
    logic [13:0] instr;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic psa;
    logic [7:0] presc;
    logic [7:0] timer;
    logic [7:0] iptr;
    logic [7:0] port_latch;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acx_regs_t;

  localparam acx_regs_t REGS_RST = '0;

  // ----------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------
  function automatic acx_op_t acx_decode(input logic [13:0] word);
    acx_op_t op;
    op = OP_NONE;
    if (word[13:9] == 5'h1f)
    begin
      op = OP_ADD_IMM;
    end
    else if (word[13:8] == 6'h39)
    begin
      op = OP_AND_IMM;
    end
    else if (word[13:8] == 6'h07)
    begin
      op = OP_ADD_REG;
    end
    else if (word[13:8] == 6'h05)
    begin
      op = OP_AND_REG;
    end
    return op;
  endfunction : acx_decode

endpackage : acx_pkg

// ### src/acx_alu.sv
// Purpose: Byte adder and AND unit with carry, nibble carry and zero results
// Assumes: Purely combinational; the caller registers the outputs
// Notes: Carry out of bit 7 and out of bit 3 come from one 9-bit and one 5-bit sum
`timescale 1ns/1ps
`default_nettype none

module acx_alu (
  // Operation select
  input wire logic i_add,
  // Operands
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  // Results
  output logic [7:0] o_res,
  output logic o_c,
  output logic o_dc,
  output logic o_z
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb
  begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    o_res = i_add ? sum[7:0] : (i_a & i_b);
    o_c = sum[8];
    o_dc = low_sum[4];
    o_z = (o_res == 8'h00);
  end

endmodule : acx_alu

`default_nettype wire

// ### src/acx_core.sv
// Purpose: Execution of add/AND immediate and add/AND file register instructions behind APB
// Assumes: Pin levels arrive asynchronously; i_clk is the oscillator
// Notes: Software writes an opcode to the instruction register; the block runs it in four clocks, eight when it writes the pointer
`timescale 1ns/1ps
`default_nettype none

module acx_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Port pins and latch
  input wire logic [7:0] i_pin_levels,
  output logic [7:0] o_port_latch,
  // Program flow
  output logic [7:0] o_instr_ptr
);
  import acx_pkg::*;

  // ----------------------------------------------------------------
  // State and memory
  // ----------------------------------------------------------------
  acx_regs_t st;
  acx_regs_t next_st;
  logic [7:0] file_ram [0:127];
  logic ram_we;
  logic [6:0] ram_addr;
  logic [7:0] ram_wdata;

  acx_op_t op;
  logic [6:0] fa;
  logic dbit;
  logic is_add;
  logic is_imm;
  logic to_file;
  logic pc_hit;
  logic commit;
  logic [7:0] operand;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic access;
  logic done;
  logic in_win;
  logic [6:0] win_idx;
  logic busy;

  // File register read, shared by the instruction operand and the APB window
  function automatic logic [7:0] rd_file(input logic [6:0] a);
    logic [7:0] v;
    v = file_ram[a];
    if (a == FILE_TIMER)
    begin
      v = st.timer;
    end
    else if (a == FILE_IPTR)
    begin
      v = st.iptr;
    end
    else if (a == FILE_FLAGS)
    begin
      v = {5'h00, st.z, st.dc, st.c};
    end
    else if (a == FILE_PORT)
    begin
      v = st.pin_sync;
    end
    return v;
  endfunction : rd_file

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  acx_alu u_alu (
    .i_add(is_add),
    .i_a(st.acc),
    .i_b(operand),
    .o_res(alu_res),
    .o_c(alu_c),
    .o_dc(alu_dc),
    .o_z(alu_z)
  );

  always_comb
  begin
    op = acx_decode(st.instr);
    fa = st.instr[6:0];
    dbit = st.instr[7];
    is_add = (op == OP_ADD_IMM) || (op == OP_ADD_REG);
    is_imm = (op == OP_ADD_IMM) || (op == OP_AND_IMM);
    operand = is_imm ? st.instr[7:0] : rd_file(fa);
    to_file = !is_imm && (op != OP_NONE) && dbit;
    pc_hit = to_file && (fa == FILE_IPTR);
    commit = (st.state == ST_EXEC) && (st.phase == LAST_PHASE);
    busy = (st.state != ST_IDLE);
    access = i_psel && i_penable;
    done = access && st.pready;
    in_win = (i_paddr[11:9] == FILE_WIN_TOP) && (i_paddr[1:0] == 2'b00);
    win_idx = i_paddr[8:2];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    ram_we = 1'b0;
    ram_addr = fa;
    ram_wdata = alu_res;
    next_st.pin_meta = i_pin_levels;
    next_st.pin_sync = st.pin_meta;

    // Timer runs once per instruction cycle, through the prescaler when assigned
    next_st.tick = st.tick + 2'd1;
    if (st.tick == LAST_PHASE)
    begin
      if (st.psa)
      begin
        next_st.presc = st.presc + 8'h01;
        if (st.presc == 8'hff)
        begin
          next_st.timer = st.timer + 8'h01;
        end
      end
      else
      begin
        next_st.timer = st.timer + 8'h01;
      end
    end

    // Instruction sequencing
    if (busy)
    begin
      next_st.phase = st.phase + 2'd1;
    end
    if (commit)
    begin
      next_st.phase = 2'd0;
      if (to_file)
      begin
        if (fa == FILE_TIMER)
        begin
          next_st.timer = alu_res;
          if (st.psa)
          begin
            next_st.presc = 8'h00;
          end
        end
        else if (fa == FILE_FLAGS)
        begin
          next_st.c = alu_res[FLAG_C];
          next_st.dc = alu_res[FLAG_DC];
        end
        else if (fa == FILE_PORT)
        begin
          next_st.port_latch = alu_res;
        end
        else if (fa != FILE_IPTR)
        begin
          ram_we = 1'b1;
        end
      end
      else if (op != OP_NONE)
      begin
        next_st.acc = alu_res;
      end
      if (op != OP_NONE)
      begin
        next_st.z = alu_z;
        if (is_add)
        begin
          next_st.c = alu_c;
          next_st.dc = alu_dc;
        end
      end
      if (pc_hit)
      begin
        next_st.iptr = alu_res;
        next_st.state = ST_NOP;
      end
      else
      begin
        next_st.iptr = st.iptr + 8'h01;
        next_st.state = ST_IDLE;
      end
    end
    else if ((st.state == ST_NOP) && (st.phase == LAST_PHASE))
    begin
      next_st.phase = 2'd0;
      next_st.state = ST_IDLE;
    end

    // APB: one wait state, then the answer
    next_st.pready = access && !st.pready;
    if (access && !st.pready)
    begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      if (in_win)
      begin
        next_st.prdata = {24'h00_0000, rd_file(win_idx)};
        next_st.pslverr = i_pwrite && busy;
      end
      else if (i_paddr == ADDR_INSTR)
      begin
        next_st.prdata = {18'h0_0000, st.instr};
        next_st.pslverr = i_pwrite && busy;
      end
      else if (i_paddr == ADDR_ACC)
      begin
        next_st.prdata = {24'h00_0000, st.acc};
        next_st.pslverr = i_pwrite && busy;
      end
      else if (i_paddr == ADDR_FLAGS)
      begin
        next_st.prdata = {29'h0000_0000, st.z, st.dc, st.c};
        next_st.pslverr = i_pwrite && busy;
      end
      else if (i_paddr == ADDR_CFG)
      begin
        next_st.prdata = {31'h0000_0000, st.psa};
      end
      else if (i_paddr == ADDR_STAT)
      begin
        next_st.prdata = {30'h0000_0000, st.state == ST_NOP, busy};
        next_st.pslverr = i_pwrite;
      end
      else if (i_paddr == ADDR_TIMER)
      begin
        next_st.prdata = {24'h00_0000, st.timer};
        next_st.pslverr = i_pwrite && busy;
      end
      else if (i_paddr == ADDR_PRESC)
      begin
        next_st.prdata = {24'h00_0000, st.presc};
        next_st.pslverr = i_pwrite;
      end
      else if (i_paddr == ADDR_IPTR)
      begin
        next_st.prdata = {24'h00_0000, st.iptr};
        next_st.pslverr = i_pwrite && busy;
      end
      else
      begin
        next_st.pslverr = 1'b1;
      end
    end
    if (done && i_pwrite && !st.pslverr)
    begin
      if (in_win)
      begin
        if (win_idx == FILE_TIMER)
        begin
          next_st.timer = i_pwdata[7:0];
          if (st.psa)
          begin
            next_st.presc = 8'h00;
          end
        end
        else if (win_idx == FILE_IPTR)
        begin
          next_st.iptr = i_pwdata[7:0];
        end
        else if (win_idx == FILE_FLAGS)
        begin
          next_st.c = i_pwdata[FLAG_C];
          next_st.dc = i_pwdata[FLAG_DC];
          next_st.z = i_pwdata[FLAG_Z];
        end
        else if (win_idx == FILE_PORT)
        begin
          next_st.port_latch = i_pwdata[7:0];
        end
        else
        begin
          ram_we = 1'b1;
          ram_addr = win_idx;
          ram_wdata = i_pwdata[7:0];
        end
      end
      else if (i_paddr == ADDR_INSTR)
      begin
        next_st.instr = i_pwdata[13:0];
        next_st.state = ST_EXEC;
        next_st.phase = 2'd0;
      end
      else if (i_paddr == ADDR_ACC)
      begin
        next_st.acc = i_pwdata[7:0];
      end
      else if (i_paddr == ADDR_FLAGS)
      begin
        next_st.c = i_pwdata[FLAG_C];
        next_st.dc = i_pwdata[FLAG_DC];
        next_st.z = i_pwdata[FLAG_Z];
      end
      else if (i_paddr == ADDR_CFG)
      begin
        next_st.psa = i_pwdata[CFG_PSA];
      end
      else if (i_paddr == ADDR_TIMER)
      begin
        next_st.timer = i_pwdata[7:0];
      end
      else if (i_paddr == ADDR_IPTR)
      begin
        next_st.iptr = i_pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st <= REGS_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (ram_we)
    begin
      file_ram[ram_addr] <= ram_wdata;
    end
  end

  always_comb
  begin
    o_prdata = st.prdata;
    o_pready = st.pready;
    o_pslverr = st.pslverr;
    o_port_latch = st.port_latch;
    o_instr_ptr = st.iptr;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_PORT_FROM_PINS: assert property (commit && !is_imm && fa == FILE_PORT |-> operand == $past(i_pin_levels, 2))
    else $error("Port operand not taken from pins");
  AST_PRESC_CLEAR: assert property (commit && to_file && fa == FILE_TIMER && st.psa |=> st.presc == 8'h00)
    else $error("Prescaler not cleared on timer write");
  AST_TWO_CYCLES: assert property (commit && pc_hit |=> (st.state == ST_NOP)[*4] ##1 st.state == ST_IDLE)
    else $error("Pointer change did not take one extra cycle");
  AST_ADD_IMM: assert property (commit && op == OP_ADD_IMM
    |=> st.acc == 8'($past(st.acc) + $past(st.instr[7:0])) && st.c == $past(alu_c))
    else $error("Add immediate result wrong");
  AST_AND_IMM: assert property (commit && op == OP_AND_IMM
    |=> st.acc == ($past(st.acc) & $past(st.instr[7:0])) && $stable(st.c) && $stable(st.dc))
    else $error("AND immediate result wrong");
  AST_ADD_REG_ACC: assert property (commit && op == OP_ADD_REG && !dbit
    |=> st.acc == 8'($past(st.acc) + $past(operand)))
    else $error("Add register to accumulator wrong");
  AST_AND_REG_FILE: assert property (commit && op == OP_AND_REG && dbit |=> $stable(st.acc))
    else $error("AND register to file changed accumulator");
  AST_FOUR_CLOCKS: assert property ($rose(st.state == ST_EXEC) |-> (st.state == ST_EXEC)[*4] ##1 st.state != ST_EXEC)
    else $error("Instruction cycle not four clocks");
  AST_ZERO_FLAG: assert property (commit && op != OP_NONE && !to_file |=> st.z == (st.acc == 8'h00))
    else $error("Zero flag does not match result");

  COV_ADD_IMM: cover property (commit && op == OP_ADD_IMM && alu_c);
  COV_PC_WRITE: cover property (commit && pc_hit);
  COV_PORT_RMW: cover property (commit && to_file && fa == FILE_PORT);
  COV_TIMER_CLR: cover property (commit && to_file && fa == FILE_TIMER && st.psa);

endmodule : acx_core

`default_nettype wire

// ### bench/acx_tb.sv
// Purpose: Self-checking bench for the accumulator execution block over APB
// Assumes: One wait state per APB transfer; results commit four clocks after the opcode write
// Notes: Random operands from a fixed seed, with hand-picked carry and zero corner cases first
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import acx_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [7:0] i_pin_levels = 8'h00;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [7:0] o_port_latch;
  logic [7:0] o_instr_ptr;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h4eb7;
  logic [31:0] rd;
  logic err;

  always #5 i_clk = ~i_clk;

  acx_core u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_pin_levels(i_pin_levels), .o_port_latch(o_port_latch),
    .o_instr_ptr(o_instr_ptr)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      $display("FAIL t=%0t no pready", $time);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    for (int i = 0; i < 30; i++)
    begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if (rd[STAT_BUSY] === 1'b0)
        break;
    end
    check(rd, 32'h0);
  endtask : wait_idle

  // Opcode write, then the pointer must hold for three clocks and move on the fourth
  task automatic run(input logic [13:0] op, input logic [7:0] iexp);
    logic [7:0] ip;
    ip = o_instr_ptr;
    apb(1'b1, ADDR_INSTR, {18'h0, op});
    check(err, 1'b0);
    repeat (3) @(posedge i_clk);
    #1 check(o_instr_ptr, ip);
    @(posedge i_clk);
    #1 check(o_instr_ptr, iexp);
  endtask : run

  // Returns {Z, DC, C, result}
  function automatic logic [10:0] model(input logic add, input logic [7:0] a, input logic [7:0] b,
                                        input logic [2:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    r = add ? s[7:0] : (a & b);
    return {r == 8'h00, add ? h[4] : fl[FLAG_DC], add ? s[8] : fl[FLAG_C], r};
  endfunction : model

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] a, b;
    logic [6:0] f;
    logic [2:0] fl;
    logic [1:0] kind;
    logic d;
    logic [10:0] e;
    logic [13:0] op;
    logic [11:0] rst_addr [4];
    logic [7:0] ca [4];
    logic [7:0] cb [4];
    rst_addr = '{ADDR_ACC, ADDR_FLAGS, ADDR_STAT, ADDR_IPTR};
    ca = '{8'hff, 8'h0f, 8'hf0, 8'h88};
    cb = '{8'h01, 8'h01, 8'h0f, 8'h78};
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (rst_addr[i])
    begin
      apb(1'b0, rst_addr[i], 32'h0);
      check(rd, 32'h0);
    end
    check(o_port_latch, 8'h00);
    // Mixed operations: corner cases first, then random
    for (int i = 0; i < 40; i++)
    begin
      kind = 2'($random(seed));
      a = 8'($random(seed));
      b = 8'($random(seed));
      fl = 3'($random(seed));
      d = 1'($random(seed));
      f = 7'h20 + 7'($random(seed) & 63);
      if (i < 8)
      begin
        a = ca[i % 4];
        b = cb[i % 4];
        kind = 2'(i / 2);
      end
      @(posedge i_clk);
      i_pin_levels <= 8'($random(seed));
      apb(1'b1, ADDR_ACC, {24'h0, a});
      apb(1'b1, ADDR_FLAGS, {29'h0, fl});
      case (kind)
        2'd0: op = 14'h3e00 | {5'h0, d, b};
        2'd1: op = 14'h3900 | {6'h0, b};
        2'd2: op = 14'h0700 | {6'h0, d, f};
        default: op = 14'h0500 | {6'h0, d, f};
      endcase
      if (kind[1])
        apb(1'b1, 12'h200 + {3'h0, f, 2'b00}, {24'h0, b});
      e = model(kind == 2'd0 || kind == 2'd2, a, b, fl);
      run(op, o_instr_ptr + 8'h01);
      wait_idle();
      apb(1'b0, ADDR_ACC, 32'h0);
      check(rd, {24'h0, (kind[1] && d) ? a : e[7:0]});
      apb(1'b0, ADDR_FLAGS, 32'h0);
      check(rd, {29'h0, e[10:8]});
      if (kind[1] && d)
      begin
        apb(1'b0, 12'h200 + {3'h0, f, 2'b00}, 32'h0);
        check(rd, {24'h0, e[7:0]});
      end
    end
    // Refused accesses: read-only, unmapped, and a write while busy
    apb(1'b1, ADDR_STAT, 32'h1);
    check(err, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    check(err, 1'b1);
    apb(1'b1, ADDR_ACC, 32'h3c);
    apb(1'b1, ADDR_INSTR, 32'h3e01);
    apb(1'b1, ADDR_ACC, 32'h77);
    check(err, 1'b1);
    wait_idle();
    apb(1'b0, ADDR_ACC, 32'h0);
    check(rd, 32'h3d);
    // Unknown opcode: one idle cycle, pointer steps, accumulator untouched
    run(14'h0000, o_instr_ptr + 8'h01);
    wait_idle();
    apb(1'b0, ADDR_ACC, 32'h0);
    check(rd, 32'h3d);
    // Read-modify-write of the port takes the pins, not the latch
    apb(1'b1, 12'h200 + {3'h0, FILE_PORT, 2'b00}, 32'hff);
    #1 check(o_port_latch, 8'hff);
    @(posedge i_clk);
    i_pin_levels <= 8'h0f;
    apb(1'b1, ADDR_ACC, 32'hff);
    run(14'h0500 | {6'h0, 1'b1, FILE_PORT}, o_instr_ptr + 8'h01);
    wait_idle();
    #1 check(o_port_latch, 8'h0f);
    // Pointer as destination costs a second, empty cycle
    apb(1'b1, ADDR_IPTR, 32'hf3);
    apb(1'b1, ADDR_ACC, 32'h55);
    run(14'h0500 | {6'h0, 1'b1, FILE_IPTR}, 8'h51);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd, 32'h3);
    wait_idle();
    check(o_instr_ptr, 8'h51);
    // Timer write clears the prescaler when it belongs to the timer
    apb(1'b1, ADDR_CFG, 32'h1);
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, ADDR_PRESC, 32'h0);
      if (rd[7:0] >= 8'h40)
        break;
    end
    check(rd[7:0] >= 8'h40, 1'b1);
    apb(1'b1, ADDR_ACC, 32'h0);
    run(14'h0700 | {6'h0, 1'b1, FILE_TIMER}, o_instr_ptr + 8'h01);
    apb(1'b0, ADDR_PRESC, 32'h0);
    check(rd[7:0] < 8'h08, 1'b1);
    wait_idle();
    final_report();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #500000;
    n_errors++;
    $display("FAIL t=%0t watchdog expired", $time);
    final_report();
  end

endmodule : testbench

`default_nettype wire
